/* logic/clock_source_pkg.sv */
package clock_source_pkg;

  localparam int CLK_MHZ = 200;

  // Wishbone word offsets (byte addresses)
  localparam logic [7:0] OSC_STATUS_ADDR = 8'h00;
  localparam logic [7:0] CLK_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'h0c;
  localparam logic [7:0] CONFIG_ADDR     = 8'h10;

  // Status bit positions
  localparam int SOSC_READY_BIT  = 7;
  localparam int MULT_READY_BIT  = 6;
  localparam int ON_CONFIG_BIT   = 5;
  localparam int HF_READY_BIT    = 4;
  localparam int HF_LOCKED_BIT   = 3;
  localparam int MF_READY_BIT    = 2;
  localparam int LF_READY_BIT    = 1;
  localparam int HF_STABLE_BIT   = 0;

  // Control register fields
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_INTSPD_LSB = 2;
  localparam int CTRL_MULT_BIT   = 6;
  localparam int CTRL_SOSCEN_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Interrupt event bit positions
  localparam int EV_FAIL_BIT     = 0;
  localparam int EV_STARTED_BIT  = 1;
  localparam int EV_MULT_BIT     = 2;

  // Startup timer, in oscillator cycles of the external source
  localparam int STARTUP_EXT_CYCLES = 1024;
  // Fail-safe window: loss declared with no external edge for this long
  localparam int FAIL_WINDOW_NS     = 2000;
  localparam int FAIL_WINDOW_CYCLES = (FAIL_WINDOW_NS * CLK_MHZ) / 1000;
  localparam int MULT_LOCK_NS       = 2000;
  localparam int MULT_LOCK_CYCLES   = (MULT_LOCK_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ext_clock_low_power_mode    = 3'h0,
    ext_clock_medium_power_mode = 3'h1,
    ext_clock_high_power_mode   = 3'h2,
    low_power_crystal_mode      = 3'h3,
    medium_gain_crystal_mode    = 3'h4,
    high_gain_crystal_mode      = 3'h5,
    external_rc_mode            = 3'h6,
    internal_oscillator_mode    = 3'h7
  } clock_mode_t;

  // Software source select
  typedef enum logic [1:0] {
    src_config   = 2'h0,
    src_internal = 2'h1,
    src_rsvd_a   = 2'h2,
    src_rsvd_b   = 2'h3
  } clock_src_t;

  // Internal speeds
  typedef enum logic [3:0] {
    spd_lf_31k   = 4'h0,
    spd_mf_500k  = 4'h7,
    spd_hf_16m   = 4'hf
  } int_speed_t;

  function automatic logic is_crystal(input logic [2:0] m);
    return (m == low_power_crystal_mode) || (m == medium_gain_crystal_mode) ||
           (m == high_gain_crystal_mode);
  endfunction

  function automatic logic is_external(input logic [2:0] m);
    return m != internal_oscillator_mode;
  endfunction

endpackage

/* logic/clock_source_select_status.sv */
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Power-up clock mode comes from configuration field
// - Three external logic clock power modes
// - Low-power, medium and high-gain crystal modes
// - External logic modes clock straight from input
// - Internal mode built from LF, MF, HF
// - Software switches source, speed and multiplier
// - Fail-safe falls back to internal on loss
// - Two-speed start runs internal while external starts
// - Startup timer holds crystal until stable
// - Bit 7 secondary oscillator ready when enabled
// - Bit 6 multiplier ready
// - Bit 5 running on configured source
// - Bit 4 HF ready, bit 3 HF 2% locked
// - Bit 2 MF ready
// - Bit 1 LF ready
// - Bit 0 HF stable within 0.5%
module clock_source_select_status
  import clock_source_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_EXT_CYCLES,
  parameter int FAIL_CYCLES    = FAIL_WINDOW_CYCLES,
  parameter int LOCK_CYCLES    = MULT_LOCK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  clock_mode_config_field,
  input  wire logic        two_speed_enable,
  input  wire logic        fail_safe_enable,
  input  wire logic        ext_clock_in,
  input  wire logic        secondary_osc_running,
  input  wire logic        lf_osc_running,
  input  wire logic        mf_osc_running,
  input  wire logic        hf_osc_running,
  input  wire logic        hf_osc_locked,
  input  wire logic        hf_osc_stable,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  output logic             sys_clk_sel_ext,
  output logic             sys_clk_sel_mult,
  output logic [3:0]       int_speed_sel,
  output logic             osc_drive_enable
);

  initial begin
    if (STARTUP_CYCLES < 1 || FAIL_CYCLES < 2 || LOCK_CYCLES < 1) begin
      $error("clock_source_select_status: bad timing parameter");
    end
  end

  // Every asynchronous input takes two flops
  logic [1:0] ext_s, sosc_s, lf_s, mf_s, hf_s, hfl_s, hfs_s;
  logic       ext_prev;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_s    <= '0;
      sosc_s   <= '0;
      lf_s     <= '0;
      mf_s     <= '0;
      hf_s     <= '0;
      hfl_s    <= '0;
      hfs_s    <= '0;
      ext_prev <= 1'b0;
    end else begin
      ext_s    <= {ext_s[0], ext_clock_in};
      sosc_s   <= {sosc_s[0], secondary_osc_running};
      lf_s     <= {lf_s[0], lf_osc_running};
      mf_s     <= {mf_s[0], mf_osc_running};
      hf_s     <= {hf_s[0], hf_osc_running};
      hfl_s    <= {hfl_s[0], hf_osc_locked};
      hfs_s    <= {hfs_s[0], hf_osc_stable};
      ext_prev <= ext_s[1];
    end
  end
  logic ext_edge;
  assign ext_edge = ext_s[1] & ~ext_prev;

  // Mode latched once after reset release; config field is static otherwise
  logic [2:0] cfg_mode;
  logic       cfg_taken;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_mode  <= internal_oscillator_mode;
      cfg_taken <= 1'b0;
    end else if (!cfg_taken) begin
      cfg_mode  <= clock_mode_config_field;
      cfg_taken <= 1'b1;
    end
  end

  // Software control register
  logic [7:0] ctrl;
  logic [2:0] irq_status, irq_mask;
  logic       wr;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr && wb_adr_i == CLK_CTRL_ADDR) begin
      ctrl <= wb_dat_i[7:0];
    end
  end

  // Crystal startup timer counts external edges, not ref_clk
  logic [$clog2(STARTUP_CYCLES+1)-1:0] ost_cnt;
  logic ext_ready;
  logic fail_seen;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || fail_seen) begin
      ost_cnt   <= '0;
      ext_ready <= 1'b0;
    end else if (!ext_ready && ext_edge) begin
      if (!is_crystal(cfg_mode) || ost_cnt == ($bits(ost_cnt))'(STARTUP_CYCLES - 1)) begin
        ext_ready <= 1'b1;
      end else begin
        ost_cnt <= ost_cnt + 1'b1;
      end
    end
  end

  // Fail-safe watchdog on external edges
  logic [$clog2(FAIL_CYCLES+1)-1:0] fail_cnt;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fail_cnt  <= '0;
      fail_seen <= 1'b0;
    end else if (!fail_safe_enable || !is_external(cfg_mode) || ext_edge) begin
      fail_cnt <= '0;
    end else if (fail_cnt == ($bits(fail_cnt))'(FAIL_CYCLES - 1)) begin
      fail_seen <= 1'b1;
    end else if (ext_ready) begin
      fail_cnt <= fail_cnt + 1'b1;
    end
  end

  // Multiplier lock delay after enable
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt;
  logic mult_ready;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !ctrl[CTRL_MULT_BIT]) begin
      lock_cnt   <= '0;
      mult_ready <= 1'b0;
    end else if (lock_cnt == ($bits(lock_cnt))'(LOCK_CYCLES - 1)) begin
      mult_ready <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Source choice: external only when configured, ready, not failed
  logic want_ext, use_ext;
  assign want_ext = is_external(cfg_mode) && ctrl[CTRL_SRC_LSB +: 2] == src_config;
  // Two-speed or not: run internal until external ready; without it hold_clock only flags the wait
  assign use_ext  = want_ext && ext_ready && !fail_seen;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sys_clk_sel_ext  <= 1'b0;
      sys_clk_sel_mult <= 1'b0;
      int_speed_sel    <= spd_hf_16m;
      osc_drive_enable <= 1'b0;
    end else begin
      sys_clk_sel_ext  <= use_ext;
      sys_clk_sel_mult <= ctrl[CTRL_MULT_BIT] & mult_ready;
      int_speed_sel    <= ctrl[CTRL_INTSPD_LSB +: 4];
      osc_drive_enable <= is_crystal(cfg_mode) & ~fail_seen;
    end
  end

  // Without two-speed, status of hold is just sel_ext low; code still runs
  logic hold_clock;
  assign hold_clock = want_ext && !ext_ready && !two_speed_enable;

  // Live status; no storage so writes cannot touch it
  logic [7:0] osc_status;
  always_comb begin
    osc_status = '0;
    osc_status[SOSC_READY_BIT] = ctrl[CTRL_SOSCEN_BIT] & sosc_s[1];
    osc_status[MULT_READY_BIT] = mult_ready;
    osc_status[ON_CONFIG_BIT]  = sys_clk_sel_ext | ~is_external(cfg_mode);
    osc_status[HF_READY_BIT]   = hf_s[1];
    osc_status[HF_LOCKED_BIT]  = hf_s[1] & hfl_s[1];
    osc_status[MF_READY_BIT]   = mf_s[1];
    osc_status[LF_READY_BIT]   = lf_s[1];
    osc_status[HF_STABLE_BIT]  = hf_s[1] & hfs_s[1];
  end

  // Interrupt events; set wins over write-one clear
  logic fail_prev, ready_prev, mult_prev;
  logic [2:0] ev;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fail_prev  <= 1'b0;
      ready_prev <= 1'b0;
      mult_prev  <= 1'b0;
    end else begin
      fail_prev  <= fail_seen;
      ready_prev <= ext_ready;
      mult_prev  <= mult_ready;
    end
  end
  always_comb begin
    ev = '0;
    ev[EV_FAIL_BIT]    = fail_seen & ~fail_prev;
    ev[EV_STARTED_BIT] = ext_ready & ~ready_prev;
    ev[EV_MULT_BIT]    = mult_ready & ~mult_prev;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      if (wr && wb_adr_i == IRQ_MASK_ADDR) begin
        irq_mask <= wb_dat_i[2:0];
      end
      if (wr && wb_adr_i == IRQ_STATUS_ADDR) begin
        irq_status <= (irq_status & ~wb_dat_i[2:0]) | ev;
      end else begin
        irq_status <= irq_status | ev;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Wishbone classic: ack one cycle after strobe, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i)
        OSC_STATUS_ADDR: wb_dat_o <= {24'h000000, osc_status};
        CLK_CTRL_ADDR:   wb_dat_o <= {24'h000000, ctrl};
        IRQ_STATUS_ADDR: wb_dat_o <= {29'h0, irq_status};
        IRQ_MASK_ADDR:   wb_dat_o <= {29'h0, irq_mask};
        CONFIG_ADDR:     wb_dat_o <= {22'h0, hold_clock, fail_seen, ext_ready,
                                      two_speed_enable, fail_safe_enable, cfg_taken, 1'b0, cfg_mode};
        default:         wb_dat_o <= '0;
      endcase
    end
  end

  // Assertions
  property p_ext_only_when_ready;
    @(posedge ref_clk) disable iff (sys_rst)
      sys_clk_sel_ext |-> $past(ext_ready) && !$past(fail_seen);
  endproperty
  a_ext_only_when_ready: assert property (p_ext_only_when_ready) else $error("ext before ready");

  property p_fail_falls_back;
    @(posedge ref_clk) disable iff (sys_rst)
      fail_seen |-> ##1 !sys_clk_sel_ext;
  endproperty
  a_fail_falls_back: assert property (p_fail_falls_back) else $error("no fallback on fail");

  property p_sosc_gated;
    @(posedge ref_clk) disable iff (sys_rst)
      !ctrl[CTRL_SOSCEN_BIT] |-> !osc_status[SOSC_READY_BIT];
  endproperty
  a_sosc_gated: assert property (p_sosc_gated) else $error("sosc ready without enable");

  property p_mult_ready_delay;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(ctrl[CTRL_MULT_BIT]) |-> !mult_ready;
  endproperty
  a_mult_ready_delay: assert property (p_mult_ready_delay) else $error("mult ready too soon");

  property p_on_config;
    @(posedge ref_clk) disable iff (sys_rst)
      (sys_clk_sel_ext && is_external(cfg_mode)) |-> osc_status[ON_CONFIG_BIT];
  endproperty
  a_on_config: assert property (p_on_config) else $error("bit5 wrong");

  sequence s_hf_up;
    hf_s[1] && hfl_s[1];
  endsequence
  property p_hf_locked;
    @(posedge ref_clk) disable iff (sys_rst)
      s_hf_up |-> osc_status[HF_LOCKED_BIT] && osc_status[HF_READY_BIT];
  endproperty
  a_hf_locked: assert property (p_hf_locked) else $error("hf status wrong");

  property p_lf_mf;
    @(posedge ref_clk) disable iff (sys_rst)
      osc_status[MF_READY_BIT] == mf_s[1] && osc_status[LF_READY_BIT] == lf_s[1];
  endproperty
  a_lf_mf: assert property (p_lf_mf) else $error("lf or mf status wrong");

  property p_ack_one;
    @(posedge ref_clk) disable iff (sys_rst)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack timing wrong");

  property p_cfg_held;
    @(posedge ref_clk) disable iff (sys_rst)
      cfg_taken |=> $stable(cfg_mode);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("config mode changed after capture");

  property p_drive_on;
    @(posedge ref_clk) disable iff (sys_rst)
      (is_crystal(cfg_mode) && !fail_seen) |=> osc_drive_enable;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("crystal driver off in crystal mode");

  property p_drive_off;
    @(posedge ref_clk) disable iff (sys_rst)
      !is_crystal(cfg_mode) |=> !osc_drive_enable;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("crystal driver on outside crystal mode");

  property p_internal_mode;
    @(posedge ref_clk) disable iff (sys_rst)
      !is_external(cfg_mode) |=> !sys_clk_sel_ext;
  endproperty
  a_internal_mode: assert property (p_internal_mode) else $error("external chosen in internal mode");

  property p_sw_internal;
    @(posedge ref_clk) disable iff (sys_rst)
      (ctrl[CTRL_SRC_LSB +: 2] != src_config) |=> !sys_clk_sel_ext;
  endproperty
  a_sw_internal: assert property (p_sw_internal) else $error("software internal choice ignored");

  property p_mult_path;
    @(posedge ref_clk) disable iff (sys_rst)
      sys_clk_sel_mult |-> $past(mult_ready);
  endproperty
  a_mult_path: assert property (p_mult_path) else $error("multiplier used before ready");

  property p_mult_drop;
    @(posedge ref_clk) disable iff (sys_rst)
      !ctrl[CTRL_MULT_BIT] |=> !mult_ready;
  endproperty
  a_mult_drop: assert property (p_mult_drop) else $error("multiplier ready while off");

  sequence s_crystal_ready_rise;
    $rose(ext_ready) && is_crystal(cfg_mode);
  endsequence
  property p_startup_count;
    @(posedge ref_clk) disable iff (sys_rst)
      s_crystal_ready_rise |-> ost_cnt == ($bits(ost_cnt))'(STARTUP_CYCLES - 1);
  endproperty
  a_startup_count: assert property (p_startup_count) else $error("crystal ready before count");

  property p_fail_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      fail_seen |=> fail_seen;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag lost");

  property p_event_sticks;
    @(posedge ref_clk) disable iff (sys_rst)
      (|ev) |=> (irq_status & $past(ev)) == $past(ev);
  endproperty
  a_event_sticks: assert property (p_event_sticks) else $error("event lost against clear");

  property p_hold_internal;
    @(posedge ref_clk) disable iff (sys_rst)
      hold_clock |=> !sys_clk_sel_ext;
  endproperty
  a_hold_internal: assert property (p_hold_internal) else $error("external used while held");

endmodule
`default_nettype wire

/* bench/ext_clock_source.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source #(
  parameter int HALF_NS = 25
) (
  input  wire logic run,
  output wire logic clk_out
);
  // Stopped source parks low, the way a dead oscillator pin settles
  logic level = 1'b0;
  always begin
    #(HALF_NS);
    level = run ? ~level : 1'b0;
  end
  assign clk_out = level;
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  import clock_source_pkg::*;
  localparam int STARTUP = 4;
  localparam int LOCKN   = 8;
  localparam logic [2:0]  MODES [3] = '{3'h2, 3'h5, 3'h6};
  localparam logic [31:0] CFGX  [3] = '{32'h72, 32'h75, 32'h236};
  localparam logic [5:0] PAT [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h06, 6'h03, 6'h05};
  localparam logic [7:0] EXP [7] = '{8'h80, 8'h02, 8'h04, 8'h10, 8'h18, 8'h00, 8'h11};
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [2:0]  mode    = 3'h0;
  logic [5:0]  osc     = 6'h00;
  logic        run     = 1'b0;
  logic        ts      = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic        sel_ext;
  logic        sel_mult;
  logic        drv;
  logic        ext_clk;
  logic [3:0]  spd;
  int          err_total = 0;
  int          compares  = 0;
  int          edges     = 0;

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ext_clk) edges++;

  ext_clock_source src (.run(run), .clk_out(ext_clk));

  clock_source_select_status #(.STARTUP_CYCLES(STARTUP), .FAIL_CYCLES(20), .LOCK_CYCLES(LOCKN)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clock_mode_config_field(mode),
    .two_speed_enable(ts), .fail_safe_enable(1'b1), .ext_clock_in(ext_clk),
    .secondary_osc_running(osc[5]), .lf_osc_running(osc[4]), .mf_osc_running(osc[3]),
    .hf_osc_running(osc[2]), .hf_osc_locked(osc[1]), .hf_osc_stable(osc[0]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq), .sys_clk_sel_ext(sel_ext),
    .sys_clk_sel_mult(sel_mult), .int_speed_sel(spd), .osc_drive_enable(drv));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Holds the request until ack is seen, giving up after 50 cycles; no latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) err_total++;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    `CHK(rdat, exp)
  endtask

  task automatic wait_ext(input logic v);
    int n;
    n = 0;
    while (sel_ext !== v && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 2000) err_total++;
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    mode    <= m;
    run     <= 1'b0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    edges = 0;
  endtask

  initial begin
    #50us;
    err_total++;
    finish_test();
  end

  initial begin
    for (int i = 0; i < 3; i++) begin
      ts <= (i != 2);
      do_reset(MODES[i]);
      `CHK(spd, 4'hf)
      rd_chk(OSC_STATUS_ADDR, 32'h0);
      rd_chk(CONFIG_ADDR, CFGX[i]);
      run <= 1'b1;
      wait_ext(1'b1);
      `CHK(edges >= (i == 1 ? STARTUP : 1), 1'b1)
      `CHK(drv, (i == 1))
      rd_chk(OSC_STATUS_ADDR, 32'h20);
      wb(1'b1, IRQ_MASK_ADDR, 32'h1);
      run <= 1'b0;
      wait_ext(1'b0);
      rd_chk(OSC_STATUS_ADDR, 32'h0);
      `CHK(irq, 1'b1)
      rd_chk(IRQ_STATUS_ADDR, 32'h3);
      wb(1'b1, IRQ_STATUS_ADDR, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHK(irq, 1'b0)
      rd_chk(IRQ_STATUS_ADDR, 32'h2);
    end
    // Secondary enable on so bit 7 follows its source
    wb(1'b1, CLK_CTRL_ADDR, 32'h80);
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk);
      osc <= PAT[k];
      repeat (4) @(posedge ref_clk);
      rd_chk(OSC_STATUS_ADDR, {24'h0, EXP[k]});
    end
    wb(1'b1, OSC_STATUS_ADDR, 32'hff);
    rd_chk(OSC_STATUS_ADDR, 32'h11);
    rd_chk(8'h20, 32'h0);
    wb(1'b1, IRQ_STATUS_ADDR, 32'h7);
    wb(1'b1, IRQ_MASK_ADDR, 32'h4);
    wb(1'b1, CLK_CTRL_ADDR, 32'h5d);
    rd_chk(OSC_STATUS_ADDR, 32'h11);
    repeat (LOCKN + 4) @(posedge ref_clk);
    rd_chk(OSC_STATUS_ADDR, 32'h51);
    `CHK(sel_mult, 1'b1)
    `CHK(spd, 4'h7)
    `CHK(irq, 1'b1)
    rd_chk(CLK_CTRL_ADDR, 32'h5d);
    // Internal mode must never hand the clock to the pin
    do_reset(internal_oscillator_mode);
    run <= 1'b1;
    repeat (100) @(posedge ref_clk);
    `CHK(sel_ext, 1'b0)
    `CHK(drv, 1'b0)
    rd_chk(OSC_STATUS_ADDR, 32'h31);
    finish_test();
  end
endmodule
`default_nettype wire
